//--- logic/mem_protect_pkg.sv
// Constants for the configuration-word memory protection block
package mem_protect_pkg;
   localparam int               CFG_WIDTH       = 14;
   // Register byte offsets
   localparam logic [7:0]       OFS_CFG_WORD    = 8'h00;
   localparam logic [7:0]       OFS_CONTROL     = 8'h04;
   localparam logic [7:0]       OFS_STATUS      = 8'h08;
   // Field positions inside the configuration word
   localparam int               BIT_LV_EN       = 13;
   localparam int               BIT_STORE_WLOCK = 11;
   localparam int               BIT_CFG_WLOCK   = 9;
   localparam int               BIT_BOOT_WLOCK  = 8;
   localparam int               BIT_APP_WLOCK   = 7;
   localparam int               BIT_STORE_EN    = 4;
   localparam int               BIT_BOOT_EN     = 3;
   localparam int               BIT_BSIZE_LO    = 0;
   localparam int               BIT_BSIZE_HI    = 2;
   // Control register bits
   localparam int               CTL_BULK_ERASE  = 0;
   localparam int               CTL_LV_SESSION  = 1;
   localparam int               CTL_EXT_RST_EN  = 2;
   // Blank value after bulk erase; unimplemented bits read as one
   localparam logic [13:0]      CFG_BLANK       = 14'h3FFF;
   // Bits that software may write; the rest are unimplemented
   localparam logic [13:0]      CFG_WMASK       = 14'h2B9F;
   localparam logic [1:0]       RESP_OKAY       = 2'h0;
   localparam logic [1:0]       RESP_SLVERR     = 2'h2;
endpackage

//--- logic/mem_protect.sv
// Configuration word memory protection with an AXI4-Lite register slave
module mem_protect
(
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   // AXI4-Lite write address and data
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   // AXI4-Lite write response
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   // AXI4-Lite read
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   // Decoded protection outputs
   output logic             lowVoltActive,
   output logic             resetPinIsReset,
   output logic             storeEnabled,
   output logic             storeWriteBlock,
   output logic             cfgWriteBlock,
   output logic             bootWriteBlock,
   output logic             appWriteBlock,
   output logic             bootEnabled,
   output logic [2:0]       bootSize
);
   logic [13:0] cfgQ, cfgD;
   logic [2:0]  ctlQ, ctlD;
   logic        refusedQ, refusedD;
   logic        awHeldQ, awHeldD, wHeldQ, wHeldD;
   logic [7:0]  awAddrQ, awAddrD;
   logic [31:0] wDataQ, wDataD;
   logic [3:0]  wStrbQ, wStrbD;
   logic        bvalidQ, bvalidD, rvalidQ, rvalidD;
   logic [1:0]  brespQ, brespD, rrespQ, rrespD;
   logic [31:0] rdataQ, rdataD;
   logic [8:0]  outD, outQ;
   logic [2:0]  bsizeQ, bsizeD;
   // Ready flags are registered so that every output leaves a flip-flop
   logic        awReadyQ, awReadyD, wReadyQ, wReadyD, arReadyQ, arReadyD;

   function automatic logic addrOk(input logic [7:0] a);
      addrOk = (a == mem_protect_pkg::OFS_CFG_WORD) || (a == mem_protect_pkg::OFS_CONTROL)
            || (a == mem_protect_pkg::OFS_STATUS);
   endfunction

   // Write channel capture and configuration update
   always_comb
   begin
      logic        doWrite;
      logic [13:0] req;
      logic [13:0] lockable;
      doWrite  = 1'b0;
      req      = cfgQ;
      lockable = 14'h0000;
      awHeldD  = awHeldQ;
      wHeldD   = wHeldQ;
      awAddrD  = awAddrQ;
      wDataD   = wDataQ;
      wStrbD   = wStrbQ;
      bvalidD  = bvalidQ;
      brespD   = brespQ;
      cfgD     = cfgQ;
      ctlD     = ctlQ;
      refusedD = refusedQ;
      if (awvalid && awready)
      begin
         awHeldD = 1'b1;
         awAddrD = awaddr;
      end
      if (wvalid && wready)
      begin
         wHeldD = 1'b1;
         wDataD = wdata;
         wStrbD = wstrb;
      end
      if (bvalidQ && bready)
         bvalidD = 1'b0;
      // Bulk erase is a one-shot command bit; clear it after use
      ctlD[mem_protect_pkg::CTL_BULK_ERASE] = 1'b0;
      if (ctlQ[mem_protect_pkg::CTL_BULK_ERASE])
         cfgD = mem_protect_pkg::CFG_BLANK;
      if (awHeldQ && wHeldQ && !bvalidQ)
      begin
         doWrite = 1'b1;
         awHeldD = 1'b0;
         wHeldD  = 1'b0;
         bvalidD = 1'b1;
         brespD  = addrOk(awAddrQ) ? mem_protect_pkg::RESP_OKAY : mem_protect_pkg::RESP_SLVERR;
      end
      if (doWrite && awAddrQ == mem_protect_pkg::OFS_CONTROL && wStrbQ[0])
         ctlD = wDataQ[2:0];
      if (doWrite && awAddrQ == mem_protect_pkg::OFS_CFG_WORD && !ctlQ[0])
      begin
         req = cfgQ;
         if (wStrbQ[0])
            req[7:0] = wDataQ[7:0];
         if (wStrbQ[1])
            req[13:8] = wDataQ[13:8];
         // Programming can only clear bits; a set needs a bulk erase
         lockable = req & mem_protect_pkg::CFG_WMASK;
         lockable = lockable | ~mem_protect_pkg::CFG_WMASK;
         req      = cfgQ & lockable;
         // Size bits frozen once the boot region is enabled
         if (!cfgQ[mem_protect_pkg::BIT_BOOT_EN])
            req[2:0] = cfgQ[2:0];
         refusedD = 1'b0;
         if (ctlQ[mem_protect_pkg::CTL_LV_SESSION] && !req[mem_protect_pkg::BIT_LV_EN]
             && cfgQ[mem_protect_pkg::BIT_LV_EN])
         begin
            req[mem_protect_pkg::BIT_LV_EN] = 1'b1;
            refusedD = 1'b1;
         end
         cfgD = req;
      end
      awReadyD = !awHeldD;
      wReadyD  = !wHeldD;
   end

   // Read channel
   always_comb
   begin
      rvalidD = rvalidQ;
      rdataD  = rdataQ;
      rrespD  = rrespQ;
      if (rvalidQ && rready)
         rvalidD = 1'b0;
      if (arvalid && arready)
      begin
         rvalidD = 1'b1;
         rrespD  = addrOk(araddr) ? mem_protect_pkg::RESP_OKAY : mem_protect_pkg::RESP_SLVERR;
         case (araddr)
            mem_protect_pkg::OFS_CFG_WORD: rdataD = {18'h00000, cfgQ};
            mem_protect_pkg::OFS_CONTROL:  rdataD = {29'h00000000, ctlQ};
            mem_protect_pkg::OFS_STATUS:   rdataD = {22'h000000, refusedQ, outQ};
            default:                       rdataD = 32'h00000000;
         endcase
      end
      arReadyD = !rvalidD;
   end

   // Decoded protection state
   always_comb
   begin
      logic storeOn, bootOn;
      storeOn = !cfgQ[mem_protect_pkg::BIT_STORE_EN];
      bootOn  = !cfgQ[mem_protect_pkg::BIT_BOOT_EN];
      outD[0] = cfgQ[mem_protect_pkg::BIT_LV_EN];
      // Low-voltage mode forces the shared pin to reset whatever the enable bit says
      outD[1] = cfgQ[mem_protect_pkg::BIT_LV_EN] | ctlQ[mem_protect_pkg::CTL_EXT_RST_EN];
      outD[2] = storeOn;
      outD[3] = storeOn && !cfgQ[mem_protect_pkg::BIT_STORE_WLOCK];
      outD[4] = !cfgQ[mem_protect_pkg::BIT_CFG_WLOCK];
      outD[5] = bootOn && !cfgQ[mem_protect_pkg::BIT_BOOT_WLOCK];
      outD[6] = !cfgQ[mem_protect_pkg::BIT_APP_WLOCK];
      outD[7] = bootOn;
      outD[8] = 1'b0;
      bsizeD  = cfgQ[mem_protect_pkg::BIT_BSIZE_HI:mem_protect_pkg::BIT_BSIZE_LO];
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cfgQ     <= mem_protect_pkg::CFG_BLANK;
         ctlQ     <= 3'h0;
         refusedQ <= 1'b0;
         awHeldQ  <= 1'b0;
         wHeldQ   <= 1'b0;
         awAddrQ  <= 8'h00;
         wDataQ   <= 32'h00000000;
         wStrbQ   <= 4'h0;
         bvalidQ  <= 1'b0;
         brespQ   <= 2'h0;
         rvalidQ  <= 1'b0;
         rdataQ   <= 32'h00000000;
         rrespQ   <= 2'h0;
         outQ     <= 9'h000;
         bsizeQ   <= 3'h0;
         awReadyQ <= 1'b1;
         wReadyQ  <= 1'b1;
         arReadyQ <= 1'b1;
      end
      else
      begin
         cfgQ     <= cfgD;
         ctlQ     <= ctlD;
         refusedQ <= refusedD;
         awHeldQ  <= awHeldD;
         wHeldQ   <= wHeldD;
         awAddrQ  <= awAddrD;
         wDataQ   <= wDataD;
         wStrbQ   <= wStrbD;
         bvalidQ  <= bvalidD;
         brespQ   <= brespD;
         rvalidQ  <= rvalidD;
         rdataQ   <= rdataD;
         rrespQ   <= rrespD;
         outQ     <= outD;
         bsizeQ   <= bsizeD;
         awReadyQ <= awReadyD;
         wReadyQ  <= wReadyD;
         arReadyQ <= arReadyD;
      end
   end

   assign awready         = awReadyQ;
   assign wready          = wReadyQ;
   assign arready         = arReadyQ;
   assign bvalid          = bvalidQ;
   assign bresp           = brespQ;
   assign rvalid          = rvalidQ;
   assign rdata           = rdataQ;
   assign rresp           = rrespQ;
   assign lowVoltActive   = outQ[0];
   assign resetPinIsReset = outQ[1];
   assign storeEnabled    = outQ[2];
   assign storeWriteBlock = outQ[3];
   assign cfgWriteBlock   = outQ[4];
   assign bootWriteBlock  = outQ[5];
   assign appWriteBlock   = outQ[6];
   assign bootEnabled     = outQ[7];
   assign bootSize        = bsizeQ;

   chk_lowvolt_refused: assert property (@(posedge core_clk) disable iff (!rst_n)
      ctlQ[mem_protect_pkg::CTL_LV_SESSION] && cfgQ[mem_protect_pkg::BIT_LV_EN]
      |=> cfgQ[mem_protect_pkg::BIT_LV_EN])
      else $error("Low-voltage enable cleared during low-voltage session");
   chk_sticky_bits: assert property (@(posedge core_clk) disable iff (!rst_n)
      !ctlQ[mem_protect_pkg::CTL_BULK_ERASE] |=> ((cfgQ & ~$past(cfgQ)) == 14'h0000))
      else $error("Protection bit released without bulk erase");
   chk_erase_blank: assert property (@(posedge core_clk) disable iff (!rst_n)
      ctlQ[mem_protect_pkg::CTL_BULK_ERASE] |=> cfgQ == mem_protect_pkg::CFG_BLANK)
      else $error("Bulk erase did not blank word");
   chk_store_lock: assert property (@(posedge core_clk) disable iff (!rst_n)
      cfgQ[mem_protect_pkg::BIT_STORE_EN] |=> !storeWriteBlock)
      else $error("Storage flash locked while disabled");
   chk_store_polarity: assert property (@(posedge core_clk) disable iff (!rst_n)
      ##1 storeEnabled == !$past(cfgQ[mem_protect_pkg::BIT_STORE_EN]))
      else $error("Storage flash enable polarity wrong");
   chk_lowvolt_pin: assert property (@(posedge core_clk) disable iff (!rst_n)
      cfgQ[mem_protect_pkg::BIT_LV_EN] |=> resetPinIsReset && lowVoltActive)
      else $error("Low-voltage mode did not force reset pin function");
   chk_boot_lock: assert property (@(posedge core_clk) disable iff (!rst_n)
      cfgQ[3] |=> !bootWriteBlock)
      else $error("Boot lock applied while boot region disabled");
   chk_region_lock: assert property (@(posedge core_clk) disable iff (!rst_n)
      !cfgQ[9] && !cfgQ[7] |=> cfgWriteBlock && appWriteBlock)
      else $error("Region lock not applied");
endmodule

//--- tb/prog_model.sv
// Programmer model: AXI4-Lite master reaching the protection registers
module prog_model
(
   // Clock
   input  wire logic        core_clk,
   // Write address and data
   output logic [7:0]       awaddr = 8'h00,
   output logic             awvalid = 1'b0,
   input  wire logic        awready,
   output logic [31:0]      wdata = 32'h0,
   output logic [3:0]       wstrb = 4'hF,
   output logic             wvalid = 1'b0,
   input  wire logic        wready,
   // Write response
   input  wire logic [1:0]  bresp,
   input  wire logic        bvalid,
   output logic             bready = 1'b0,
   // Read
   output logic [7:0]       araddr = 8'h00,
   output logic             arvalid = 1'b0,
   input  wire logic        arready,
   input  wire logic [31:0] rdata,
   input  wire logic [1:0]  rresp,
   input  wire logic        rvalid,
   output logic             rready = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   // No high-voltage entry exists here, so programming goes over the register path
   // Ready is looked at on the falling edge, where it has settled, and acted on at the next rise
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic ta;
      logic tw;
      logic done;
      done = 1'b0;
      @(posedge core_clk);
      awaddr  <= a;
      awvalid <= 1'b1;
      wdata   <= d;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      while (!done)
      begin
         @(negedge core_clk);
         ta   = awvalid & awready;
         tw   = wvalid & wready;
         done = bvalid;
         r    = bresp;
         @(posedge core_clk);
         if (ta)
            awvalid <= 1'b0;
         if (tw)
            wvalid <= 1'b0;
      end
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ta;
      logic done;
      done = 1'b0;
      @(posedge core_clk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      while (!done)
      begin
         @(negedge core_clk);
         ta   = arvalid & arready;
         done = rvalid;
         d    = rdata;
         r    = rresp;
         @(posedge core_clk);
         if (ta)
            arvalid <= 1'b0;
      end
      rready <= 1'b0;
   endtask
endmodule

//--- tb/testbench.sv
// Self-checking bench for the memory protection block
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin errors++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] CFGA = mem_protect_pkg::OFS_CFG_WORD;
   localparam logic [7:0] CTLA = mem_protect_pkg::OFS_CONTROL;
   localparam logic [7:0] STSA = mem_protect_pkg::OFS_STATUS;
   logic        core_clk = 1'b0;
   logic        rst_n = 1'b0;
   int          errors = 0;
   int          num_checks = 0;
   int          cycles = 0;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, rdV;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, resp;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic        lowVoltActive, resetPinIsReset, storeEnabled, storeWriteBlock;
   logic        cfgWriteBlock, bootWriteBlock, appWriteBlock, bootEnabled;
   logic [2:0]  bootSize;
   logic [10:0] outs;
   assign outs = {lowVoltActive, resetPinIsReset, storeEnabled, storeWriteBlock, cfgWriteBlock,
                  bootWriteBlock, appWriteBlock, bootEnabled, bootSize};
   mem_protect dut_u (.core_clk(core_clk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .lowVoltActive(lowVoltActive), .resetPinIsReset(resetPinIsReset),
      .storeEnabled(storeEnabled), .storeWriteBlock(storeWriteBlock),
      .cfgWriteBlock(cfgWriteBlock),
      .bootWriteBlock(bootWriteBlock), .appWriteBlock(appWriteBlock),
      .bootEnabled(bootEnabled), .bootSize(bootSize));
   prog_model prog_u (.core_clk(core_clk), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
   always #25 core_clk = ~core_clk;
   task automatic give_verdict();
      $display("checks=%0d mismatches=%0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Decoded outputs lag the word by a register, so two edges pass first
   task automatic ck(input logic [10:0] e);
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      `CHK(outs, e)
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] d, input logic [10:0] e);
      prog_u.wr(a, d, resp);
      `CHK(resp, mem_protect_pkg::RESP_OKAY)
      ck(e);
   endtask
   task automatic rreg(input logic [7:0] a, input logic [31:0] e);
      prog_u.rd(a, rdV, resp);
      `CHK(resp, mem_protect_pkg::RESP_OKAY)
      `CHK(rdV, e)
   endtask
   task automatic rcfg(input logic [31:0] e);
      rreg(CFGA, e);
   endtask
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         errors++;
         give_verdict();
      end
   end
   initial
   begin
      repeat (20) @(posedge core_clk);
      rst_n <= 1'b1;
      ck(11'h607);
      rcfg(32'h0000_3FFF);
      $display("test blank word done");
      wreg(CFGA, 32'h0000_3FEF, 11'h707);
      wreg(CFGA, 32'h0000_37FF, 11'h787);
      wreg(CFGA, 32'h0000_3FFF, 11'h787);
      rcfg(32'h0000_37EF);
      wreg(CFGA, 32'h0000_3C7D, 11'h7D5);
      wreg(CFGA, 32'h0000_3FF7, 11'h7FD);
      wreg(CFGA, 32'h0000_3FF8, 11'h7FD);
      rcfg(32'h0000_3465);
      $display("test region locks done");
      wreg(CTLA, 32'h0000_0001, 11'h607);
      rcfg(32'h0000_3FFF);
      rreg(CTLA, 32'h0000_0000);
      wreg(CFGA, 32'h0000_37FF, 11'h607);
      wreg(CTLA, 32'h0000_0002, 11'h607);
      wreg(CFGA, 32'h0000_1FFF, 11'h607);
      rcfg(32'h0000_37FF);
      rreg(STSA, 32'h0000_0203);
      wreg(CTLA, 32'h0000_0000, 11'h607);
      wreg(CFGA, 32'h0000_1FFF, 11'h007);
      rreg(STSA, 32'h0000_0000);
      wreg(CTLA, 32'h0000_0004, 11'h207);
      rreg(CTLA, 32'h0000_0004);
      $display("test programming mode done");
      prog_u.wr(8'h0C, 32'h0000_0000, resp);
      `CHK(resp, mem_protect_pkg::RESP_SLVERR)
      rcfg(32'h0000_17FF);
      prog_u.rd(8'h0C, rdV, resp);
      `CHK(resp, mem_protect_pkg::RESP_SLVERR)
      $display("test unmapped done");
      give_verdict();
   end
endmodule
